/* logic/pcd_regs.svh */
/*
  Register offsets, field positions, reset values and fixed codes of the
  clock control block. Assumes byte addresses on a 32-bit register port.
*/
// Function
// RL1 - Post divider codes 1-5 give /2../32
// RL2 - Multiplier is field value plus one
// RL3 - Pre divider field+1, forced /1 on fast RC
// RL4 - Input select: 1 fast RC, 0 primary
// RL5 - Band 0 bypass, 1-5 bands, rest reserved
// RL6 - PLL fields load from config word
// RL7 - PLL writes need unlock sequence first
// RL8 - PLL writes ignored while running on PLL
// RL9 - Reference integer divider, zero bypasses division
// RL10 - Enable bit switches reference generator on
// RL11 - Idle stop bit halts generator in Idle
// RL12 - Output enable drives reference pin
// RL13 - Run in sleep, ignored for sources 0,1
// RL14 - Divider change applies on switch request
// RL15 - Request status follows enable, hardware driven
// RL16 - Software waits until enable matches status
// RL17 - Software keeps source while request active
// RL18 - Source select code map
// RL19 - Trim adds N/512 to divisor
// RL20 - Trim ignored when integer divider zero
// RL21 - Bus clock is system clock/(div+1)
// RL22 - Ready low blocks divisor writes
// RL23 - Bus enable resets one, bus 1 stays on
// RL24 - System divide is field plus one
// RL25 - System divide ignored without slew enables
`ifndef PCD_REGS_SVH
`define PCD_REGS_SVH

`define PCD_OFF_PLL        8'h00
`define PCD_OFF_REF_BASE   8'h10
`define PCD_REF_STRIDE     8'h08
`define PCD_REF_TRIM_OFS   8'h04
`define PCD_OFF_PB_BASE    8'h40
`define PCD_PB_STRIDE      8'h04
`define PCD_OFF_SLEW       8'h60

`define PCD_PLL_POST_LSB   24
`define PCD_PLL_MULT_LSB   16
`define PCD_PLL_PRE_LSB    8
`define PCD_PLL_ISEL_BIT   7
`define PCD_PLL_BAND_LSB   0
`define PCD_REF_DIV_LSB    16
`define PCD_REF_ON_BIT     15
`define PCD_REF_IDLE_BIT   13
`define PCD_REF_OE_BIT     12
`define PCD_REF_REF_RUN_IN_SLEEP_BIT   11
`define PCD_REF_DIVSW_BIT  9
`define PCD_REF_ACT_BIT    8
`define PCD_REF_SEL_LSB    0
`define PCD_TRIM_LSB       23
`define PCD_PB_EN_BIT      15
`define PCD_PB_RDY_BIT     11
`define PCD_PB_DIV_LSB     0
`define PCD_SLEW_DIV_LSB   16
`define PCD_SLEW_UP_BIT    2
`define PCD_SLEW_DN_BIT    1

`define PCD_PB_DIV_RST     7'h01
`define PCD_PB_LAST_RST    7'h00
`define PCD_SLEW_UP_ENABLE_RST       1'b1
`define PCD_CURRENT_OSC_SELECT_PLL       3'h1
`define PCD_SRC_PB1        4'h1
`define PCD_POST_MIN       3'h1
`define PCD_POST_MAX       3'h5
`define PCD_BAND_BYPASS    3'h0
`define PCD_BAND_MAX       3'h5

`endif

/* logic/pcd_pkg.sv */
/*
  Types of the clock control block: bus request, PLL settings, channel
  and whole-module state. Assumes the counts below are fixed per chip.
*/
package pcd_pkg;
  localparam int PCD_NREF = 4;
  localparam int PCD_NPB  = 7;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pcd_bus_req_t;

  typedef struct packed {
    logic [2:0] post;
    logic [6:0] mult;
    logic [2:0] pre;
    logic       isel;
    logic [2:0] band;
  } pcd_pll_cfg_t;

  typedef struct packed {
    logic [7:0] mult_factor;
    logic [3:0] pre_factor;
    logic [5:0] post_factor;
    logic       bypass;
    logic       band_valid;
    logic       input_fast_rc;
  } pcd_pll_out_t;

  typedef struct packed {
    logic        on;
    logic        idle_stop;
    logic        oe;
    logic        ref_run_in_sleep;
    logic        divsw;
    logic        active;
    logic [14:0] div;
    logic [3:0]  sel;
    logic [8:0]  trim;
    logic [14:0] act_div;
    logic [8:0]  act_trim;
    logic [14:0] cnt;
    logic [8:0]  acc;
    logic        extra;
    logic        out;
  } pcd_ref_t;

  typedef struct packed {
    logic       en;
    logic       rdy;
    logic       tick;
    logic [6:0] div;
    logic [6:0] pend;
    logic [6:0] cnt;
  } pcd_pb_t;

  typedef struct packed {
    pcd_pll_cfg_t                pll;
    logic                        cfg_loaded;
    pcd_pll_out_t                pll_out;
    pcd_ref_t [PCD_NREF-1:0]     refs;
    logic [PCD_NREF-1:0]         ref_pin;
    logic [PCD_NREF-1:0]         ref_oe;
    pcd_pb_t [PCD_NPB-1:0]       pbs;
    logic [3:0]                  system_clock_divide;
    logic                        slew_up_enable;
    logic                        slew_down_enable;
    logic [3:0]                  sdcnt;
    logic                        sdtick;
    logic [15:0]                 src_s1;
    logic [15:0]                 src_s2;
    logic [15:0]                 src_s3;
    logic [31:0]                 rdata;
  } pcd_state_t;
endpackage

/* logic/pcd_clock_ctrl.sv */
/*
  System PLL settings, four fractional reference clock generators, seven
  peripheral bus clock dividers and the system clock divider.
  Assumes one 20 MHz clock; source oscillators arrive as levels and are
  synchronised here; idle, sleep, unlock and current oscillator come from
  logic on the same clock.
*/
`timescale 1ns/1ps
`include "pcd_regs.svh"

module pcd_clock_ctrl
  import pcd_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire pcd_bus_req_t         bus,
  output logic [31:0]               rd_data,
  input  wire pcd_pll_cfg_t         cfg_word,
  input  wire logic                 sys_unlocked,
  input  wire logic [2:0]           current_osc_select,
  input  wire logic                 idle_mode,
  input  wire logic                 sleep_mode,
  input  wire logic [15:0]          src_clk_in,
  output pcd_pll_out_t              pll_out,
  output logic [PCD_NREF-1:0]       ref_clock_out_pin,
  output logic [PCD_NREF-1:0]       ref_clock_out_oe,
  output logic [PCD_NPB-1:0]        periph_bus_clock,
  output logic                      system_clock_divide_tick
);

  function automatic pcd_pll_out_t pll_decode(input pcd_pll_cfg_t c);
    pcd_pll_out_t o;
    o = '0;
    o.mult_factor = {1'b0, c.mult} + 8'h01;
    o.pre_factor = c.isel ? 4'h1 : ({1'b0, c.pre} + 4'h1);
    o.post_factor = (c.post >= `PCD_POST_MIN && c.post <= `PCD_POST_MAX) ?
                    (6'h01 << c.post) : 6'h00;
    o.bypass = (c.band == `PCD_BAND_BYPASS);
    o.band_valid = (c.band <= `PCD_BAND_MAX);
    o.input_fast_rc = c.isel;
    return o;
  endfunction

  function automatic logic [7:0] ref_addr(input int unsigned idx, input logic trim);
    return `PCD_OFF_REF_BASE + 8'(idx * 8) + (trim ? `PCD_REF_TRIM_OFS : 8'h00);
  endfunction

  function automatic logic [7:0] pb_addr(input int unsigned idx);
    return `PCD_OFF_PB_BASE + 8'(idx * 4);
  endfunction

  logic [1:0]  rst_sync;
  logic        rst_core_n;
  pcd_state_t  s_reg;
  pcd_state_t  s_next;
  logic [15:0] src_tick;
  pcd_ref_t    rc;
  pcd_ref_t    rn;
  pcd_pb_t     pc;
  pcd_pb_t     pn;
  logic        run;
  logic        term;
  logic [9:0]  fsum;
  logic [3:0]  sd_eff;
  logic [31:0] rword;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync[1];

  always_comb begin
    s_next = s_reg;
    rc = '0;
    rn = '0;
    pc = '0;
    pn = '0;
    run = 1'b0;
    term = 1'b0;
    fsum = 10'h000;
    rword = 32'h0000_0000;
    // Source synchronisers, edge on the settled copy
    s_next.src_s1 = src_clk_in;
    s_next.src_s2 = s_reg.src_s1;
    s_next.src_s3 = s_reg.src_s2;
    src_tick = s_reg.src_s2 & ~s_reg.src_s3;
    src_tick[0] = 1'b1;                                        // RL18
    src_tick[1] = s_reg.pbs[0].tick;                           // RL18
    src_tick[6] = 1'b0;
    src_tick[15:10] = 6'h00;

    // PLL settings
    if (!s_reg.cfg_loaded) begin
      s_next.pll = cfg_word;                                   // RL6
      s_next.cfg_loaded = 1'b1;
    end else if (bus.wr && bus.addr == `PCD_OFF_PLL && sys_unlocked // RL7
                 && current_osc_select != `PCD_CURRENT_OSC_SELECT_PLL) begin   // RL8
      s_next.pll.post = bus.wdata[`PCD_PLL_POST_LSB +: 3];
      s_next.pll.mult = bus.wdata[`PCD_PLL_MULT_LSB +: 7];
      s_next.pll.pre  = bus.wdata[`PCD_PLL_PRE_LSB +: 3];
      s_next.pll.isel = bus.wdata[`PCD_PLL_ISEL_BIT];
      s_next.pll.band = bus.wdata[`PCD_PLL_BAND_LSB +: 3];
    end
    s_next.pll_out = pll_decode(s_reg.pll);                    // RL1 RL2 RL3 RL4 RL5

    // Reference generators
    for (int i = 0; i < PCD_NREF; i++) begin
      rc = s_reg.refs[i];
      rn = rc;
      rn.active = rc.on;                                       // RL15
      run = rc.active && rc.on && !(idle_mode && rc.idle_stop)  // RL11
            && !(sleep_mode && !(rc.ref_run_in_sleep && rc.sel > `PCD_SRC_PB1)); // RL13
      term = (rc.act_div == 15'h0000) ||                       // RL9
             (({1'b0, rc.cnt} + 16'h0001) >= ({1'b0, rc.act_div} + {15'h0000, rc.extra}));
      if (!rc.on) begin
        rn.act_div = rc.div;
        rn.act_trim = rc.trim;
        rn.divsw = 1'b0;                                       // RL14
        rn.cnt = 15'h0000;
        rn.acc = 9'h000;
        rn.extra = 1'b0;
        rn.out = 1'b0;                                         // RL10
      end else if (run && src_tick[rc.sel]) begin
        if (term) begin
          rn.out = ~rc.out;
          rn.cnt = 15'h0000;
          if (rc.act_div != 15'h0000) begin                    // RL20
            fsum = {1'b0, rc.acc} + {1'b0, rc.act_trim};       // RL19
            rn.acc = fsum[8:0];
            rn.extra = fsum[9];
          end
          if (rc.divsw) begin
            rn.act_div = rc.div;                               // RL14
            rn.act_trim = rc.trim;
            rn.acc = 9'h000;
            rn.extra = 1'b0;
            rn.divsw = 1'b0;
          end
        end else begin
          rn.cnt = rc.cnt + 15'h0001;
        end
      end
      if (bus.wr && bus.addr == ref_addr(i, 1'b0)) begin
        rn.div = bus.wdata[`PCD_REF_DIV_LSB +: 15];
        rn.on = bus.wdata[`PCD_REF_ON_BIT];
        rn.idle_stop = bus.wdata[`PCD_REF_IDLE_BIT];
        rn.oe = bus.wdata[`PCD_REF_OE_BIT];
        rn.ref_run_in_sleep = bus.wdata[`PCD_REF_REF_RUN_IN_SLEEP_BIT];
        rn.sel = bus.wdata[`PCD_REF_SEL_LSB +: 4];
        if (bus.wdata[`PCD_REF_DIVSW_BIT]) begin
          rn.divsw = 1'b1;                                     // RL14
        end
      end
      if (bus.wr && bus.addr == ref_addr(i, 1'b1)) begin
        rn.trim = bus.wdata[`PCD_TRIM_LSB +: 9];
      end
      s_next.refs[i] = rn;
      s_next.ref_pin[i] = rc.out & rc.oe;                      // RL12
      s_next.ref_oe[i] = rc.oe;
    end

    // Peripheral bus dividers
    for (int j = 0; j < PCD_NPB; j++) begin
      pc = s_reg.pbs[j];
      pn = pc;
      pn.tick = 1'b0;
      if (pc.cnt >= pc.div) begin
        pn.cnt = 7'h00;
        pn.tick = pc.en;                                       // RL21 RL23
        if (!pc.rdy) begin
          pn.div = pc.pend;
          pn.rdy = 1'b1;
        end
      end else begin
        pn.cnt = pc.cnt + 7'h01;
      end
      if (bus.wr && bus.addr == pb_addr(j)) begin
        if (j != 0 || bus.wdata[`PCD_PB_EN_BIT]) begin
          pn.en = bus.wdata[`PCD_PB_EN_BIT];                   // RL23
        end
        if (pc.rdy) begin                                      // RL22
          pn.pend = bus.wdata[`PCD_PB_DIV_LSB +: 7];
          pn.rdy = 1'b0;
        end
      end
      s_next.pbs[j] = pn;
    end

    // System clock divider
    sd_eff = (s_reg.slew_up_enable || s_reg.slew_down_enable) ? s_reg.system_clock_divide : 4'h0; // RL25
    if (s_reg.sdcnt >= sd_eff) begin                           // RL24
      s_next.sdcnt = 4'h0;
      s_next.sdtick = 1'b1;
    end else begin
      s_next.sdcnt = s_reg.sdcnt + 4'h1;
      s_next.sdtick = 1'b0;
    end
    if (bus.wr && bus.addr == `PCD_OFF_SLEW) begin
      s_next.system_clock_divide = bus.wdata[`PCD_SLEW_DIV_LSB +: 4];
      s_next.slew_up_enable = bus.wdata[`PCD_SLEW_UP_BIT];
      s_next.slew_down_enable = bus.wdata[`PCD_SLEW_DN_BIT];
    end

    // Read port
    if (bus.addr == `PCD_OFF_PLL) begin
      rword[`PCD_PLL_POST_LSB +: 3] = s_reg.pll.post;
      rword[`PCD_PLL_MULT_LSB +: 7] = s_reg.pll.mult;
      rword[`PCD_PLL_PRE_LSB +: 3] = s_reg.pll.pre;
      rword[`PCD_PLL_ISEL_BIT] = s_reg.pll.isel;
      rword[`PCD_PLL_BAND_LSB +: 3] = s_reg.pll.band;
    end
    for (int i = 0; i < PCD_NREF; i++) begin
      if (bus.addr == ref_addr(i, 1'b0)) begin
        rword[`PCD_REF_DIV_LSB +: 15] = s_reg.refs[i].div;
        rword[`PCD_REF_ON_BIT] = s_reg.refs[i].on;
        rword[`PCD_REF_IDLE_BIT] = s_reg.refs[i].idle_stop;
        rword[`PCD_REF_OE_BIT] = s_reg.refs[i].oe;
        rword[`PCD_REF_REF_RUN_IN_SLEEP_BIT] = s_reg.refs[i].ref_run_in_sleep;
        rword[`PCD_REF_DIVSW_BIT] = s_reg.refs[i].divsw;
        rword[`PCD_REF_ACT_BIT] = s_reg.refs[i].active;        // RL15
        rword[`PCD_REF_SEL_LSB +: 4] = s_reg.refs[i].sel;
      end
      if (bus.addr == ref_addr(i, 1'b1)) begin
        rword[`PCD_TRIM_LSB +: 9] = s_reg.refs[i].trim;
      end
    end
    for (int j = 0; j < PCD_NPB; j++) begin
      if (bus.addr == pb_addr(j)) begin
        rword[`PCD_PB_EN_BIT] = s_reg.pbs[j].en;
        rword[`PCD_PB_RDY_BIT] = s_reg.pbs[j].rdy;             // RL22
        rword[`PCD_PB_DIV_LSB +: 7] = s_reg.pbs[j].div;
      end
    end
    if (bus.addr == `PCD_OFF_SLEW) begin
      rword[`PCD_SLEW_DIV_LSB +: 4] = s_reg.system_clock_divide;
      rword[`PCD_SLEW_UP_BIT] = s_reg.slew_up_enable;
      rword[`PCD_SLEW_DN_BIT] = s_reg.slew_down_enable;
    end
    s_next.rdata = bus.rd ? rword : 32'h0000_0000;
  end

  always_ff @(posedge sys_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      s_reg <= '0;
      for (int j = 0; j < PCD_NPB; j++) begin
        s_reg.pbs[j].en <= 1'b1;                               // RL23
        s_reg.pbs[j].rdy <= 1'b1;
        s_reg.pbs[j].div <= (j == PCD_NPB - 1) ? `PCD_PB_LAST_RST : `PCD_PB_DIV_RST; // RL21
        s_reg.pbs[j].pend <= (j == PCD_NPB - 1) ? `PCD_PB_LAST_RST : `PCD_PB_DIV_RST;
      end
      s_reg.slew_up_enable <= `PCD_SLEW_UP_ENABLE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rdata;
  assign pll_out = s_reg.pll_out;
  assign ref_clock_out_pin = s_reg.ref_pin;
  assign ref_clock_out_oe = s_reg.ref_oe;
  assign system_clock_divide_tick = s_reg.sdtick;
  always_comb begin
    for (int j = 0; j < PCD_NPB; j++) begin
      periph_bus_clock[j] = s_reg.pbs[j].tick;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_core_n);

  // PLL register checks
  a_pll_locked_wr: assert property ( // RL8
    bus.wr && bus.addr == `PCD_OFF_PLL && current_osc_select == `PCD_CURRENT_OSC_SELECT_PLL
    && s_reg.cfg_loaded |=> s_reg.pll == $past(s_reg.pll))
    else $error("PLL write taken while running on PLL");

  a_pll_unlock_wr: assert property ( // RL7
    bus.wr && bus.addr == `PCD_OFF_PLL && !sys_unlocked && s_reg.cfg_loaded
    |=> s_reg.pll == $past(s_reg.pll))
    else $error("PLL write taken without unlock");

  a_cfg_load_pll: assert property ( // RL6
    $rose(s_reg.cfg_loaded) |-> s_reg.pll == $past(cfg_word))
    else $error("PLL settings not loaded from config");

  a_post_div_map: assert property ( // RL1
    s_reg.pll.post == 3'h5 |=> pll_out.post_factor == 6'h20)
    else $error("Post divider code 5 not divide by 32");

  a_post_div_rsvd: assert property ( // RL1
    s_reg.pll.post == 3'h0 |=> pll_out.post_factor == 6'h00)
    else $error("Reserved post divider code not flagged");

  a_mult_plus_one: assert property ( // RL2
    s_reg.pll.mult == 7'h7F |=> pll_out.mult_factor == 8'h80)
    else $error("Multiplier top code not 128");

  a_pre_forced_one: assert property ( // RL3
    s_reg.pll.isel |=> pll_out.pre_factor == 4'h1 && pll_out.input_fast_rc)
    else $error("Pre divider not forced on fast RC");

  a_band_bypass: assert property ( // RL5
    s_reg.pll.band == 3'h0 |=> pll_out.bypass && pll_out.band_valid)
    else $error("Band code 0 not bypass");

  // Reference generator checks
  a_ref_active: assert property ( // RL15
    s_reg.refs[0].on != s_reg.refs[0].active |=> s_reg.refs[0].active == $past(s_reg.refs[0].on))
    else $error("Request status does not follow enable");

  a_ref_off_pin: assert property ( // RL10
    !s_reg.refs[0].on [*2] |=> !ref_clock_out_pin[0])
    else $error("Reference pin toggles while disabled");

  a_ref_oe_pin: assert property ( // RL12
    !s_reg.refs[0].oe |=> !ref_clock_out_pin[0] && !ref_clock_out_oe[0])
    else $error("Reference pin driven without output enable");

  a_ref_idle_hold: assert property ( // RL11
    idle_mode && s_reg.refs[0].idle_stop && s_reg.refs[0].on
    |=> s_reg.refs[0].out == $past(s_reg.refs[0].out))
    else $error("Reference runs in idle with idle stop");

  a_divsw_off_clr: assert property ( // RL14
    s_reg.refs[0].divsw && !s_reg.refs[0].on && !bus.wr |=> !s_reg.refs[0].divsw)
    else $error("Switch request stuck while disabled");

  a_ref_switch_hold: assert property ( // RL14
    s_reg.refs[0].on && !s_reg.refs[0].divsw
    |=> s_reg.refs[0].act_div == $past(s_reg.refs[0].act_div))
    else $error("Divider changed without switch request");

  a_trim_ignored: assert property ( // RL20
    s_reg.refs[0].act_div == 15'h0000 && s_reg.refs[0].on |=> !s_reg.refs[0].extra)
    else $error("Trim applied with zero divider");

  a_ref_src_reserved: assert property ( // RL18
    s_reg.refs[0].sel == 4'h6 && s_reg.refs[0].on |=> s_reg.refs[0].out == $past(s_reg.refs[0].out))
    else $error("Reserved source produced a tick");

  // Bus divider checks
  a_pb1_always_on: assert property ( // RL23
    s_reg.pbs[0].en)
    else $error("Bus 1 clock disabled");

  a_pb_off_quiet: assert property ( // RL23
    !s_reg.pbs[2].en |=> !periph_bus_clock[2])
    else $error("Disabled bus clock pulsed");

  a_pb_rdy_block: assert property ( // RL22
    bus.wr && bus.addr == pb_addr(1) && !s_reg.pbs[1].rdy
    |=> s_reg.pbs[1].pend == $past(s_reg.pbs[1].pend))
    else $error("Divisor write taken while not ready");

  a_pb_div_two: assert property ( // RL21
    periph_bus_clock[0] && s_reg.pbs[0].div == 7'h01 && s_reg.pbs[0].rdy
    |=> !periph_bus_clock[0] ##1 periph_bus_clock[0])
    else $error("Bus clock period not divisor plus one");

  // System divide checks
  a_system_clock_divide_ignored: assert property ( // RL25
    !s_reg.slew_up_enable && !s_reg.slew_down_enable && s_reg.sdcnt == 4'h0 |=> system_clock_divide_tick)
    else $error("System divide applied without slew enables");

  a_system_clock_divide_wait: assert property ( // RL24
    s_reg.slew_up_enable && s_reg.system_clock_divide == 4'h3 && s_reg.sdcnt < 4'h3 |=> !system_clock_divide_tick)
    else $error("System tick before divide period ends");

  // Scenario covers
  c_divsw_done: cover property (s_reg.refs[0].on && $fell(s_reg.refs[0].divsw));
  c_pb_switch: cover property ($rose(s_reg.pbs[1].rdy));
  c_pll_write: cover property ($changed(s_reg.pll) && s_reg.cfg_loaded);
  c_ref_toggle: cover property ($rose(ref_clock_out_pin[0]));

endmodule

/* testbench/pcd_clock_ctrl_tb.sv */
/*
  Self-checking bench for the clock control block: registers, PLL view,
  reference generators, bus dividers and system divide tick.
  Assumes the offsets and field positions of pcd_regs.svh.
*/
`timescale 1ns/1ps
`include "pcd_regs.svh"

module pcd_clock_ctrl_tb;
  import pcd_pkg::*;
  localparam int LIMIT = 20000;
  localparam int RON   = 1 << `PCD_REF_ON_BIT;
  localparam int ROE   = 1 << `PCD_REF_OE_BIT;
  localparam int RIDL  = 1 << `PCD_REF_IDLE_BIT;
  localparam int REF_RUN_IN_SLEEP  = 1 << `PCD_REF_REF_RUN_IN_SLEEP_BIT;
  localparam int RSW   = 1 << `PCD_REF_DIVSW_BIT;
  localparam int RACT  = 1 << `PCD_REF_ACT_BIT;

  logic                 sys_clk;
  logic                 rst_n;
  pcd_bus_req_t         bus;
  logic [31:0]          rd_data;
  pcd_pll_cfg_t         cfg_word;
  pcd_pll_cfg_t         pm;
  logic                 sys_unlocked;
  logic [2:0]           current_osc_select;
  logic                 idle_mode;
  logic                 sleep_mode;
  logic [15:0]          src_clk_in;
  pcd_pll_out_t         pll_out;
  logic [PCD_NREF-1:0]  ref_clock_out_pin;
  logic [PCD_NREF-1:0]  ref_clock_out_oe;
  logic [PCD_NPB-1:0]   periph_bus_clock;
  logic                 system_clock_divide_tick;
  logic [31:0]          seed = 32'h0001531E;
  logic [3:0]           ph = 4'h0;
  logic [31:0]          v;
  int                   mismatches;
  int                   n_checks;
  int                   cycles;
  int                   c;

  pcd_clock_ctrl DUT (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .bus                      (bus),
    .rd_data                  (rd_data),
    .cfg_word                 (cfg_word),
    .sys_unlocked             (sys_unlocked),
    .current_osc_select       (current_osc_select),
    .idle_mode                (idle_mode),
    .sleep_mode               (sleep_mode),
    .src_clk_in               (src_clk_in),
    .pll_out                  (pll_out),
    .ref_clock_out_pin        (ref_clock_out_pin),
    .ref_clock_out_oe         (ref_clock_out_oe),
    .periph_bus_clock         (periph_bus_clock),
    .system_clock_divide_tick (system_clock_divide_tick)
  );

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Every source oscillator rises once per four cycles
  always @(posedge sys_clk) begin
    ph <= ph + 4'h1;
    src_clk_in <= {16{ph[1]}};
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      results();
    end
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] pll_word(input pcd_pll_cfg_t p);
    return {5'h00, p.post, 1'b0, p.mult, 5'h00, p.pre, p.isel, 4'h0, p.band};
  endfunction

  function automatic logic [31:0] pll_exp(input pcd_pll_cfg_t p);
    pcd_pll_out_t o;
    int post;
    post = p.post;
    o.mult_factor = 8'(int'(p.mult) + 1);
    o.pre_factor = p.isel ? 4'h1 : 4'(int'(p.pre) + 1);
    o.post_factor = (post >= 1 && post <= 5) ? 6'(1 << post) : 6'h00;
    o.bypass = (p.band == 3'h0);
    o.band_valid = (int'(p.band) <= 5);
    o.input_fast_rc = p.isel;
    return 32'(o);
  endfunction

  function automatic logic [7:0] ra(input int n);
    return 8'(`PCD_OFF_REF_BASE + n * `PCD_REF_STRIDE);
  endfunction

  function automatic logic sig(input int k);
    if (k < 4) return ref_clock_out_pin[k];
    if (k < 11) return periph_bus_clock[k-4];
    return system_clock_divide_tick;
  endfunction

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input int d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'(d), wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    bus <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    bus <= '0;
    #1;
    d = rd_data;
  endtask

  // Toggles of a reference pin, or high cycles of a pulse, in 24 cycles
  task automatic cnt(input int k, output int n);
    logic p;
    logic s;
    n = 0;
    repeat (12) @(posedge sys_clk);
    #1;
    p = sig(k);
    repeat (24) begin
      @(posedge sys_clk);
      #1;
      s = sig(k);
      if (k >= 4 ? s === 1'b1 : s !== p) n++;
      p = s;
    end
  endtask

  // Waits until the request status follows the enable bit
  task automatic ref_set(input int n, input int w);
    logic [31:0] d;
    wr(ra(n), w);
    repeat (8) begin
      rd(ra(n), d);
      if (d[`PCD_REF_ACT_BIT] === d[`PCD_REF_ON_BIT]) break;
    end
    chk("ref_active", 32'(d[`PCD_REF_ACT_BIT]), 32'((w & RON) != 0));
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    bus = '0;
    cfg_word = pcd_pll_cfg_t'(17'(xs()));
    sys_unlocked = 1'b0;
    current_osc_select = 3'h0;
    idle_mode = 1'b0;
    sleep_mode = 1'b0;
    mismatches = 0;
    n_checks = 0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    pm = cfg_word;
    rd(`PCD_OFF_PLL, v);
    chk("pll_reg", v, pll_word(pm));
    chk("pll_out", 32'(pll_out), pll_exp(pm));
    for (int i = 0; i < 16; i++) begin
      pcd_pll_cfg_t p;
      p = pcd_pll_cfg_t'(17'(xs()));
      p.post = 3'(i >> 1);
      p.band = 3'(~(i >> 1));
      if (i == 15) p.mult = 7'h7F;
      @(posedge sys_clk);
      sys_unlocked <= (i % 4 != 1);
      current_osc_select <= (i % 4 == 2) ? `PCD_CURRENT_OSC_SELECT_PLL : 3'(i % 4 == 3 ? 2 : 0);
      wr(`PCD_OFF_PLL, int'(pll_word(p)));
      if (i % 4 == 0 || i % 4 == 3) pm = p;
      rd(`PCD_OFF_PLL, v);
      chk("pll_reg", v, pll_word(pm));
      chk("pll_out", 32'(pll_out), pll_exp(pm));
    end
    rd(8'h3C, v);
    chk("unmapped", v, 32'h00000000);
    for (int m = 0; m < PCD_NPB; m++) begin
      rd(8'(`PCD_OFF_PB_BASE + 4 * m), v);
      chk("pb_reset", v, m < 6 ? 32'h00008801 : 32'h00008800);
      cnt(4 + m, c);
      chk("pb_pulses", 32'(c), m < 6 ? 32'h0000000C : 32'h00000018);
    end
    @(posedge sys_clk);
    bus <= '{addr: 8'h44, wdata: 32'h00008003, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '{addr: 8'h44, wdata: 32'h00008005, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    bus <= '0;
    cnt(5, c);
    chk("pb_pulses", 32'(c), 32'h00000006);
    rd(8'h44, v);
    chk("pb_reg", v, 32'h00008803);
    wr(8'h40, 32'h00000001);
    @(posedge sys_clk);
    rd(8'h40, v);
    chk("pb1_on", v, 32'h00008801);
    wr(8'h48, 32'h00000001);
    cnt(6, c);
    chk("pb_off", 32'(c), 32'h00000000);
    wr(`PCD_OFF_SLEW, 32'h00030004);
    cnt(11, c);
    chk("sys_tick", 32'(c), 32'h00000006);
    wr(`PCD_OFF_SLEW, 32'h00030000);
    cnt(11, c);
    chk("sys_tick", 32'(c), 32'h00000018);
    ref_set(0, 2 << 16);
    ref_set(0, (2 << 16) | RON | ROE);
    cnt(0, c);
    chk("ref_div2", 32'(c), 32'h0000000C);
    chk("ref_oe", 32'(ref_clock_out_oe[0]), 32'h00000001);
    wr(ra(0), (3 << 16) | RON | ROE);
    cnt(0, c);
    chk("ref_hold", 32'(c), 32'h0000000C);
    wr(ra(0), (3 << 16) | RON | ROE | RSW);
    cnt(0, c);
    chk("ref_div3", 32'(c), 32'h00000008);
    rd(ra(0), v);
    chk("ref_reg", v, 32'((3 << 16) | RON | ROE | RACT));
    wr(ra(0) + `PCD_REF_TRIM_OFS, 256 << 23);
    wr(ra(0), (1 << 16) | RON | ROE | RSW);
    cnt(0, c);
    chk("ref_trim", 32'(c), 32'h00000010);
    wr(ra(0), RON | ROE | RSW);
    cnt(0, c);
    chk("ref_div0", 32'(c), 32'h00000018);
    wr(ra(0), RON);
    cnt(0, c);
    chk("ref_pin_off", 32'(c), 32'h00000000);
    chk("ref_oe", 32'(ref_clock_out_oe[0]), 32'h00000000);
    wr(ra(0), RON | ROE | RIDL);
    @(posedge sys_clk);
    idle_mode <= 1'b1;
    cnt(0, c);
    chk("ref_idle", 32'(c), 32'h00000000);
    wr(ra(0), RON | ROE);
    cnt(0, c);
    chk("ref_idle_run", 32'(c), 32'h00000018);
    @(posedge sys_clk);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b1;
    wr(ra(0), RON | ROE | REF_RUN_IN_SLEEP);
    cnt(0, c);
    chk("ref_sleep", 32'(c), 32'h00000000);
    wr(ra(0) + `PCD_REF_TRIM_OFS, 0);
    for (int s = 1; s < 10; s++) begin
      ref_set(0, RSW | (s - 1));
      ref_set(0, s);
      @(posedge sys_clk);
      sleep_mode <= (s > 1);
      ref_set(0, (1 << 16) | RON | ROE | REF_RUN_IN_SLEEP | s);
      cnt(0, c);
      chk("ref_src", 32'(c), s == 1 ? 32'h0000000C : s == 6 ? 32'h0 : 32'h6);
    end
    @(posedge sys_clk);
    sleep_mode <= 1'b0;
    for (int n = 1; n < PCD_NREF; n++) begin
      ref_set(n, RON | ROE);
      cnt(n, c);
      chk("ref_chan", 32'(c), 32'h00000018);
    end
    results();
  end
endmodule
